//--- rtl/isc_pkg.sv
// isc_pkg: shared constants for the interpolation sequencing control ends
// assumes a 50 MHz ref_clk and a 16-bit parallel register port with 3 address bits
package isc_pkg;
  localparam int CLK_MHZ = 50;
  // register port addresses
  localparam logic [2:0] ADDR_CMD = 3'h0;
  localparam logic [2:0] ADDR_MODE = 3'h5;
  localparam logic [2:0] ADDR_BP_FIRST = 3'h2;
  // commands
  localparam logic [7:0] CMD_LINE2 = 8'h30;
  localparam logic [7:0] CMD_BP3 = 8'h35;
  localparam logic [7:0] CMD_BP_WEN = 8'h36;
  localparam logic [7:0] CMD_BP_WDIS = 8'h37;
  localparam logic [7:0] CMD_BP_PUSH = 8'h38;
  localparam logic [7:0] CMD_BP_CLR = 8'h39;
  localparam logic [7:0] CMD_DEC_EN = 8'h3b;
  localparam logic [7:0] CMD_DEC_DIS = 8'h3c;
  localparam logic [7:0] CMD_CLR = 8'h3d;
  // mode configuration fields
  localparam int MODE_BP_IRQ = 15;
  localparam int MODE_SEG_IRQ = 14;
  localparam int MODE_CVS_HI = 9;
  localparam int MODE_CVS_LO = 8;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  // main status fields
  localparam int ST_BUSY = 8;
  localparam int ST_NEXT = 9;
  localparam int ST_ERR = 4;
  localparam int ST_SC_LO = 13;
  // stack
  localparam int BP_DEPTH = 3;
  localparam int BP_WORDS = 6;
  localparam logic [1:0] SC_MAX = 2'h3;
  // output pulse high width, fixed whatever range is in use
  localparam int PULSE_HIGH_NS = 100;
  localparam int PULSE_HIGH_CYC = (PULSE_HIGH_NS * CLK_MHZ + 999) / 1000;
  // range select codes
  localparam logic [1:0] RANGE_PRIMARY = 2'h0;
  localparam logic [1:0] RANGE_SECOND = 2'h1;
  localparam logic [1:0] RANGE_THIRD = 2'h2;
  // host apb map
  localparam logic [7:0] APB_WRITE = 8'h00;
  localparam logic [7:0] APB_READ = 8'h04;
  localparam logic [7:0] APB_RDATA = 8'h08;
  localparam logic [7:0] APB_IRQ = 8'h0c;
  typedef enum logic [1:0] {ISC_IRQ_OFF, ISC_IRQ_LOW, ISC_IRQ_HIGH} isc_irq_t;
endpackage

//--- rtl/isc_port_if.sv
// isc_port_if: parallel register port and interrupt pin between host and device
// assumes both ends run on the same ref_clk
`timescale 1ns/10ps
`default_nettype none
interface isc_port_if;
  logic [2:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic host_irq_pin_o;
  logic host_irq_pin_oe;
  logic host_irq_pin_n;
  // pin level: driven value when enabled, pulled up otherwise
  assign host_irq_pin_n = host_irq_pin_oe ? host_irq_pin_o : 1'b1;
  modport dev (input addr, input wdata, input wr, input rd, output rdata, output host_irq_pin_o,
    output host_irq_pin_oe);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input host_irq_pin_n);
endinterface
`default_nettype wire

//--- rtl/isc_device.sv
// isc_device: segment queue, pattern stack, vector range select and interrupt pin
// assumes the motion engine reports busy, segment end, errors and axis steps
// Contract
// - stack falling 2 to 1 pulls pin low
// - host refills; stacking command releases pin
// - clear command releases pattern interrupt
// - pattern interpolation end floats low pin
// - host selects vector mode bits 8,9
// - one axis primary range, two second
// - three axes pulsing use third range
// - two-axis mode valid during three-axis run
// - pulse high width fixed, period stretched
// - ready flag in status; refuse when 0
// - ready rises once queued segment starts
// - pulses continue across segments seamlessly
// - ready rising with enable pulls pin low
// - next segment write drives pin high
// - clear command floats pin in continuous
// - error drops queued segment, stop here
// - host checks errors before each segment
// - host keeps speed and segment length
// - host keeps axis assignment fixed
// - host avoids all-zero segments
// - decel enable/disable; enable ignored driving
// - stacking command pushes words, max three
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module isc_device
  import isc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  isc_port_if.dev port,
  input wire logic drive_busy,
  input wire logic seg_done,
  input wire logic drive_err,
  input wire logic bp_pop,
  input wire logic [2:0] axis_step,
  output logic seg_start,
  output logic [7:0] seg_cmd,
  output logic [1:0] range_sel,
  output logic [2:0] axis_pulse,
  output logic decel_en,
  output logic [1:0] bp_count,
  output logic [16*BP_WORDS-1:0] bp_top
);
  logic [15:0] mode_config_reg;
  logic [1:0] pattern_stack_count;
  logic [15:0] bp_work_reg [BP_WORDS];
  logic [15:0] bp_stack_reg [BP_DEPTH][BP_WORDS];
  logic bp_wen_reg;
  logic queued_reg;
  logic [7:0] queued_cmd_reg;
  logic err_reg;
  logic busy_d_reg;
  logic bp_mode_reg;
  logic [7:0] seg_cmd_reg;
  logic [15:0] rdata_reg;
  isc_irq_t irq_reg;
  logic [1:0] range_reg;
  logic [2:0] pulse_reg;
  logic [7:0] pulse_cnt_reg [3];
  logic decel_reg;
  logic start_reg;
  logic cmd_wr;
  logic [7:0] cmd;
  logic interp_cmd;
  logic next_segment_ready;
  logic seg_accept;
  logic start_now;
  logic push;
  logic pop;
  logic interp_end;
  logic [15:0] main_status_reg;
  function automatic logic [1:0] count_axes(input logic [2:0] s);
    count_axes = {1'b0, s[0]} + {1'b0, s[1]} + {1'b0, s[2]};
  endfunction
  assign cmd_wr = port.wr && port.addr == ADDR_CMD;
  assign cmd = port.wdata[7:0];
  assign interp_cmd = cmd >= CMD_LINE2 && cmd <= CMD_BP3;
  assign next_segment_ready = !queued_reg;
  assign seg_accept = cmd_wr && interp_cmd && next_segment_ready;
  assign start_now = queued_reg && (!drive_busy || seg_done) && !drive_err;
  assign push = cmd_wr && cmd == CMD_BP_PUSH && pattern_stack_count != SC_MAX;
  assign pop = bp_pop && pattern_stack_count != 2'h0;
  assign interp_end = busy_d_reg && !drive_busy;
  assign pattern_stack_count = bp_count;
  always_comb
  begin
    main_status_reg = 16'h0000;
    main_status_reg[ST_BUSY] = drive_busy;
    main_status_reg[ST_NEXT] = next_segment_ready;
    main_status_reg[ST_ERR] = err_reg;
    main_status_reg[ST_SC_LO+1:ST_SC_LO] = pattern_stack_count;
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      rdata_reg <= 16'h0000;
    else if (port.rd)
      rdata_reg <= port.addr == ADDR_CMD ? main_status_reg : mode_config_reg;
  end
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      mode_config_reg <= MODE_RESET;
    else if (port.wr && port.addr == ADDR_MODE && !bp_wen_reg)
      mode_config_reg <= port.wdata;
    else if (interp_end)
      mode_config_reg[MODE_SEG_IRQ] <= 1'b0;
  end
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      decel_reg <= 1'b0;
    else if (cmd_wr && cmd == CMD_DEC_EN && !drive_busy)
      decel_reg <= 1'b1;
    else if (cmd_wr && cmd == CMD_DEC_DIS)
      decel_reg <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      bp_wen_reg <= 1'b0;
    else if (cmd_wr && cmd == CMD_BP_WEN)
      bp_wen_reg <= 1'b1;
    else if (cmd_wr && cmd == CMD_BP_WDIS)
      bp_wen_reg <= 1'b0;
  end
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      bp_work_reg <= '{default: 16'h0000};
    else if (port.wr && bp_wen_reg && port.addr >= ADDR_BP_FIRST)
      bp_work_reg[port.addr - ADDR_BP_FIRST] <= port.wdata;
  end
  // entry 0 is the one the engine consumes; pushes land behind the last entry
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      bp_count <= 2'h0;
      bp_stack_reg <= '{default: '{default: 16'h0000}};
    end
    else if (cmd_wr && (cmd == CMD_CLR || cmd == CMD_BP_CLR))
      bp_count <= 2'h0;
    else
    begin
      if (pop)
        for (int e = 0; e < BP_DEPTH - 1; e++)
          bp_stack_reg[e] <= bp_stack_reg[e + 1];
      if (push)
        bp_stack_reg[pop ? bp_count - 2'h1 : bp_count] <= bp_work_reg;
      bp_count <= bp_count + {1'b0, push} - {1'b0, pop};
    end
  end
  always_comb
  begin
    for (int w = 0; w < BP_WORDS; w++)
      bp_top[16*w +: 16] = bp_stack_reg[0][w];
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      queued_reg <= 1'b0;
      queued_cmd_reg <= 8'h00;
    end
    else if (drive_err)
      queued_reg <= 1'b0;
    else if (seg_accept)
    begin
      queued_reg <= 1'b1;
      queued_cmd_reg <= cmd;
    end
    else if (start_now)
      queued_reg <= 1'b0;
  end
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      start_reg <= 1'b0;
      seg_cmd_reg <= 8'h00;
      bp_mode_reg <= 1'b0;
      busy_d_reg <= 1'b0;
    end
    else
    begin
      start_reg <= start_now && !seg_accept;
      busy_d_reg <= drive_busy;
      if (start_now && !seg_accept)
      begin
        seg_cmd_reg <= queued_cmd_reg;
        bp_mode_reg <= queued_cmd_reg >= CMD_BP3 - 8'h01;
      end
    end
  end
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      err_reg <= 1'b0;
    else if (drive_err)
      err_reg <= 1'b1;
    else if (seg_accept || (cmd_wr && cmd == CMD_CLR))
      err_reg <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin; a new event wins over a release in the same cycle
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      irq_reg <= ISC_IRQ_OFF;
    else if (mode_config_reg[MODE_BP_IRQ] && pop && bp_count == 2'h2)
      irq_reg <= ISC_IRQ_LOW;
    else if (mode_config_reg[MODE_SEG_IRQ] && start_reg && drive_busy && !bp_mode_reg)
      irq_reg <= ISC_IRQ_LOW;
    else if (interp_end)
      irq_reg <= ISC_IRQ_OFF;
    else if (cmd_wr && cmd == CMD_CLR)
      irq_reg <= ISC_IRQ_OFF;
    else if (push && bp_mode_reg)
      irq_reg <= ISC_IRQ_OFF;
    else if (seg_accept && irq_reg == ISC_IRQ_LOW)
      irq_reg <= ISC_IRQ_HIGH;
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      range_reg <= RANGE_PRIMARY;
    else if (|axis_step)
    begin
      if (!mode_config_reg[MODE_CVS_HI] && mode_config_reg[MODE_CVS_LO])
        case (count_axes(axis_step))
          2'h2: range_reg <= RANGE_SECOND;
          2'h3: range_reg <= RANGE_THIRD;
          default: range_reg <= RANGE_PRIMARY;
        endcase
      else
        range_reg <= RANGE_PRIMARY;
    end
  end
  // high time counted here, never from the range, so only the period stretches
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pulse_reg <= 3'h0;
      pulse_cnt_reg <= '{default: 8'h00};
    end
    else
      for (int a = 0; a < 3; a++)
        if (axis_step[a])
        begin
          pulse_reg[a] <= 1'b1;
          pulse_cnt_reg[a] <= 8'(PULSE_HIGH_CYC - 1);
        end
        else if (pulse_cnt_reg[a] != 8'h00)
          pulse_cnt_reg[a] <= pulse_cnt_reg[a] - 8'h01;
        else
          pulse_reg[a] <= 1'b0;
  end
  assign port.rdata = rdata_reg;
  assign port.host_irq_pin_oe = irq_reg != ISC_IRQ_OFF;
  assign port.host_irq_pin_o = irq_reg == ISC_IRQ_HIGH;
  assign seg_start = start_reg;
  assign seg_cmd = seg_cmd_reg;
  assign range_sel = range_reg;
  assign axis_pulse = pulse_reg;
  assign decel_en = decel_reg;
endmodule
`default_nettype wire

//--- rtl/isc_host.sv
// isc_host: apb slave that turns software orders into register port cycles
// assumes software follows the segment and error checks; zero wait apb slave
`timescale 1ns/10ps
`default_nettype none
module isc_host
  import isc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  isc_port_if.host port,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic [2:0] addr_reg;
  logic [15:0] wdata_reg;
  logic wr_reg;
  logic rd_reg;
  logic cap_reg;
  logic [15:0] rdata_reg;
  logic rvalid_reg;
  logic access;
  logic known;

  // software is expected to check the error and ready bits between segments
  assign access = psel && penable;
  assign known = paddr == APB_WRITE || paddr == APB_READ || paddr == APB_RDATA || paddr == APB_IRQ;

  ////////////////////////////////////////////////////////////////////////////
  // port cycles: one clock each

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      addr_reg <= 3'h0;
      wdata_reg <= 16'h0000;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      cap_reg <= 1'b0;
    end
    else
    begin
      wr_reg <= access && pwrite && paddr == APB_WRITE;
      rd_reg <= access && pwrite && paddr == APB_READ;
      cap_reg <= rd_reg;
      if (access && pwrite && (paddr == APB_WRITE || paddr == APB_READ))
      begin
        addr_reg <= pwdata[18:16];
        wdata_reg <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end
    else if (cap_reg)
    begin
      rdata_reg <= port.rdata;
      rvalid_reg <= 1'b1;
    end
    else if (access && pwrite && paddr == APB_READ)
      rvalid_reg <= 1'b0;
  end

  always_comb
  begin
    case (paddr)
      APB_RDATA: prdata = {15'h0000, rvalid_reg, rdata_reg};
      APB_IRQ: prdata = {31'h00000000, !port.host_irq_pin_n};
      default: prdata = 32'h00000000;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = access && !known;
  assign port.addr = addr_reg;
  assign port.wdata = wdata_reg;
  assign port.wr = wr_reg;
  assign port.rd = rd_reg;
endmodule
`default_nettype wire

//--- bench/isc_assertions.sv
// isc_assertions: interrupt pin release and drive checks on the register port
// assumes it sits beside the port interface, same ref_clk
`timescale 1ns/10ps
`default_nettype none
module isc_assertions
  import isc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic host_irq_pin_o,
  input wire logic host_irq_pin_oe,
  input wire logic host_irq_pin_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  logic cmd_w;
  logic seg_w;
  logic [7:0] op;
  assign op = wdata[7:0];
  assign cmd_w = wr && addr == ADDR_CMD;
  assign seg_w = cmd_w && op >= CMD_LINE2 && op <= 8'h33;
  ////////////////////////////////////////
  // a new event in the same cycle would win; the bench keeps them apart
  clr_float_a: assert property (cmd_w && op == CMD_CLR |=> !host_irq_pin_oe)
    else $error("pin still driven after clear");
  push_float_a: assert property (!host_irq_pin_n && cmd_w && op == CMD_BP_PUSH |=> host_irq_pin_n)
    else $error("pin still low after push");
  seg_high_a: assert property (!host_irq_pin_n && seg_w |=> host_irq_pin_oe && host_irq_pin_o)
    else $error("pin not driven high after segment write");
  // pin driven high means a segment is queued, so a further one is refused
  refuse_hold_a: assert property (host_irq_pin_oe && host_irq_pin_o && seg_w |=> host_irq_pin_oe)
    else $error("refused segment changed pin");
  float_first_a: assert property ($rose(host_irq_pin_oe) |-> !host_irq_pin_o)
    else $error("pin enabled without going low first");
  high_cause_a: assert property ($rose(host_irq_pin_o) |-> $past(seg_w) && !$past(host_irq_pin_n))
    else $error("pin driven high without a segment write while low");
  cover property (cmd_w && op == CMD_CLR);
  cover property (!host_irq_pin_n ##1 host_irq_pin_n);
  cover property (host_irq_pin_oe && host_irq_pin_o && seg_w);
endmodule
`default_nettype wire

//--- bench/testbench.sv
// testbench: apb orders through host to device, engine driven by the bench
// assumes zero wait apb slave and the port walk of the host
`timescale 1ns/10ps
`default_nettype none
module testbench
  import isc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, slv_err, seg_start, decel_en, pin_n, oe;
  logic drive_busy = 1'b0, seg_done = 1'b0, drive_err = 1'b0, bp_pop = 1'b0;
  logic [2:0] axis_step = 3'h0, axis_pulse;
  logic [7:0] seg_cmd;
  logic [1:0] range_sel, bp_count;
  logic [16*BP_WORDS-1:0] bp_top;
  logic [15:0] st;
  logic [2:0] pat [4] = '{3'h1, 3'h3, 3'h7, 3'h7};
  int errors = 0, cmp_count = 0, starts = 0, n;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (seg_start === 1'b1) starts <= starts + 1;
  assign pin_n = u_isc_port_if.host_irq_pin_n;
  assign oe = u_isc_port_if.host_irq_pin_oe;
  ////////////////////////////////////////
  isc_port_if u_isc_port_if ();
  isc_host u_isc_host (.ref_clk(ref_clk), .reset(reset), .port(u_isc_port_if), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  isc_device u_isc_device (.ref_clk(ref_clk), .reset(reset), .port(u_isc_port_if), .drive_busy(drive_busy),
    .seg_done(seg_done), .drive_err(drive_err), .bp_pop(bp_pop), .axis_step(axis_step), .seg_start(seg_start),
    .seg_cmd(seg_cmd), .range_sel(range_sel), .axis_pulse(axis_pulse), .decel_en(decel_en),
    .bp_count(bp_count), .bp_top(bp_top));
  isc_assertions u_isc_assertions (.ref_clk(ref_clk), .reset(reset), .addr(u_isc_port_if.addr),
    .wdata(u_isc_port_if.wdata), .wr(u_isc_port_if.wr), .host_irq_pin_o(u_isc_port_if.host_irq_pin_o),
    .host_irq_pin_oe(oe), .host_irq_pin_n(pin_n));
  ////////////////////////////////////////
  task close_out();
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until pready is seen; one idle edge keeps strobes from double assignment
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    r = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    if (k >= 50)
    begin
      errors++;
      close_out();
    end
  endtask
  task pw(input logic [2:0] a, input logic [15:0] d);
    apb(1'b1, APB_WRITE, {13'h0, a, d});
    repeat (3) @(posedge ref_clk);
  endtask
  task cmd(input logic [7:0] c);
    pw(ADDR_CMD, {8'h00, c});
  endtask
  task prd(input logic [2:0] a);
    int k;
    apb(1'b1, APB_READ, {13'h0, a, 16'h0});
    repeat (3) @(posedge ref_clk);
    k = 0;
    do
    begin
      apb(1'b0, APB_RDATA, 32'h0);
      k++;
    end
    while (r[16] !== 1'b1 && k < 20);
    st = r[15:0];
    if (k >= 20)
    begin
      errors++;
      close_out();
    end
  endtask
  // v: error, segment end, pop, axis steps
  task eng(input logic [5:0] v);
    {drive_err, seg_done, bp_pop, axis_step} <= v;
    @(posedge ref_clk);
    {drive_err, seg_done, bp_pop, axis_step} <= 6'h00;
    repeat (3) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk("decel reset", decel_en, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", slv_err, 1'b1);
    drive_busy <= 1'b1;
    cmd(CMD_DEC_EN);
    chk("decel busy", decel_en, 1'b0);
    drive_busy <= 1'b0;
    cmd(CMD_DEC_EN);
    chk("decel on", decel_en, 1'b1);
    cmd(CMD_DEC_DIS);
    chk("decel off", decel_en, 1'b0);
    pw(ADDR_MODE, 16'h0100);
    for (int k = 0; k < 4; k++)
    begin
      if (k == 3)
        pw(ADDR_MODE, MODE_RESET);
      axis_step <= pat[k];
      @(posedge ref_clk);
      axis_step <= 3'h0;
      n = 0;
      repeat (12)
      begin
        @(posedge ref_clk);
        if (axis_pulse[0] === 1'b1)
          n++;
      end
      chk("range", range_sel, k < 3 ? k : 0);
      chk("width", n, PULSE_HIGH_CYC);
    end
    pw(ADDR_MODE, 16'h8000);
    cmd(CMD_BP_WEN);
    for (int k = 0; k < BP_WORDS; k++)
      pw(ADDR_BP_FIRST + 3'(k), 16'ha000 + 16'(k));
    for (int k = 1; k < 5; k++)
    begin
      cmd(CMD_BP_PUSH);
      chk("count", bp_count, k < 3 ? k : 3);
    end
    chk("word", bp_top[15:0], 16'ha000);
    prd(ADDR_CMD);
    chk("sc", st[ST_SC_LO+:2], SC_MAX);
    cmd(CMD_BP3);
    drive_busy <= 1'b1;
    eng(6'h08);
    chk("pin 3to2", pin_n, 1'b1);
    eng(6'h08);
    chk("pin 2to1", pin_n, 1'b0);
    apb(1'b0, APB_IRQ, 32'h0);
    chk("irq reg", r[0], 1'b1);
    cmd(CMD_BP_PUSH);
    chk("pin push", pin_n, 1'b1);
    eng(6'h08);
    cmd(CMD_CLR);
    chk("pin clr", pin_n, 1'b1);
    chk("count clr", bp_count, 2'h0);
    cmd(CMD_BP_PUSH);
    cmd(CMD_BP_PUSH);
    eng(6'h08);
    chk("pin again", pin_n, 1'b0);
    drive_busy <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("pin end", pin_n, 1'b1);
    cmd(CMD_BP_WDIS);
    pw(ADDR_MODE, 16'h4000);
    n = starts;
    cmd(CMD_LINE2);
    drive_busy <= 1'b1;
    cmd(8'h31);
    prd(ADDR_CMD);
    chk("next queued", st[ST_NEXT], 1'b0);
    cmd(8'h32);
    chk("starts", starts, n + 1);
    eng(6'h10);
    chk("seg", seg_cmd, 8'h31);
    chk("pin next", pin_n, 1'b0);
    prd(ADDR_CMD);
    chk("next ready", st[ST_NEXT], 1'b1);
    cmd(8'h32);
    chk("oe high", oe, 1'b1);
    chk("pin high", pin_n, 1'b1);
    cmd(8'h33);
    eng(6'h10);
    chk("seg", seg_cmd, 8'h32);
    cmd(CMD_CLR);
    chk("oe clr", oe, 1'b0);
    cmd(8'h33);
    eng(6'h20);
    prd(ADDR_CMD);
    chk("err", st[ST_ERR], 1'b1);
    eng(6'h10);
    chk("starts err", starts, n + 3);
    cmd(8'h33);
    eng(6'h10);
    chk("seg reload", seg_cmd, 8'h33);
    chk("pin reload", pin_n, 1'b0);
    drive_busy <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("oe end", oe, 1'b0);
    prd(ADDR_MODE);
    chk("seg irq en", st[MODE_SEG_IRQ], 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
